/* File: nr_pkg.sv */
// Shared constants for the denoise stream port and its streaming partner
package nr_pkg;
    localparam int NR_WIDTH = 8;
    localparam int NR_COMPS = 3;
    localparam int NR_Y_POS = 0;
    localparam int NR_CR_POS = 1;
    localparam int NR_CB_POS = 2;
    localparam int NR_LINE_LEN = 1920;
    localparam int NR_FIX_DELAY = 18;
    localparam int NR_PIPE_REGS = 2;
    localparam int NR_STRENGTH_W = 2;
    localparam logic [1:0] NR_STRENGTH = 2'h2;
    localparam logic [1:0] NR_STRENGTH_RESET = 2'h0;
    localparam logic NR_WRITE_DONE = 1'b1;
    localparam int NR_WEIGHT_SUM = 4;
    localparam int NR_WEIGHT_SHIFT = 2;
    localparam int NR_FIFO_DEPTH = 4;
    localparam int NR_CLK_PERIOD_NS = 8;
endpackage

/* File: nr_stream_if.sv */
// Video stream bundle between the partner core and the denoise stream port
interface nr_stream_if #(
    parameter int WIDTH = 8
);
    logic [3*WIDTH-1:0] in_data;
    logic in_hblank;
    logic in_vblank;
    logic in_valid;
    logic in_video_clk;
    logic in_vsync;
    logic in_hsync;
    logic in_interlace_field_flag;
    logic in_chroma_active;
    logic [3*WIDTH-1:0] out_data;
    logic out_hblank;
    logic out_vblank;
    logic out_valid;

    modport dev (
        input in_data, in_hblank, in_vblank, in_valid,
        input in_video_clk, in_vsync, in_hsync, in_interlace_field_flag, in_chroma_active,
        output out_data, out_hblank, out_vblank, out_valid
    );

    modport peer (
        output in_data, in_hblank, in_vblank, in_valid,
        output in_video_clk, in_vsync, in_hsync, in_interlace_field_flag, in_chroma_active,
        input out_data, out_hblank, out_vblank, out_valid
    );
endinterface

/* File: nr_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
module nr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != FULL_COUNT);
    assign out_valid = (count != '0);
    assign out_data = store[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == LAST_IDX) ? '0 : AW'(p + 1'b1);
    endfunction

    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= (AW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            count <= (AW+1)'(count - 1'b1);
        end
    end
endmodule

/* File: nr_peer.sv */
// Partner video core end: feeds the input stream from a FIFO and collects the output stream
module nr_peer import nr_pkg::*; #(
    parameter int WIDTH = NR_WIDTH,
    parameter int FIFO_DEPTH = NR_FIFO_DEPTH
) (
    nr_stream_if.peer vid,
    input wire logic clk,
    input wire logic rst,
    input wire logic [3*WIDTH-1:0] tx_data,
    input wire logic tx_hblank,
    input wire logic tx_vblank,
    input wire logic tx_active,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic drain_en,
    output logic [3*WIDTH-1:0] rx_data,
    output logic rx_hblank,
    output logic rx_vblank,
    output logic rx_valid
);
    localparam int DW = NR_COMPS * WIDTH;
    localparam int FW = DW + 3;

    logic [FW-1:0] fifo_out;
    logic fifo_valid;
    logic pop;

    assign pop = fifo_valid && drain_en;

    nr_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_data({tx_active, tx_vblank, tx_hblank, tx_data}),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_out),
        .out_valid(fifo_valid),
        .out_ready(pop)
    );

    // Stream driven straight from flops on the shared clock
    always_ff @(posedge clk) begin // [R1]
        if (rst) begin
            vid.in_data <= '0;
            vid.in_hblank <= 1'b0;
            vid.in_vblank <= 1'b0;
            vid.in_valid <= 1'b0;
        end else if (pop) begin
            vid.in_data <= fifo_out[DW-1:0];
            vid.in_hblank <= fifo_out[DW];
            vid.in_vblank <= fifo_out[DW+1];
            vid.in_valid <= fifo_out[DW+2];
        end else begin
            // Starved: blanking flags hold, pixel marked invalid
            vid.in_data <= '0;
            vid.in_valid <= 1'b0;
        end
    end

    // The shared core clock is the pixel clock, so no separate video clock toggles
    assign vid.in_video_clk = 1'b0; // [R14]
    assign vid.in_vsync = 1'b0;
    assign vid.in_hsync = 1'b0;
    assign vid.in_interlace_field_flag = 1'b0;
    assign vid.in_chroma_active = 1'b0;

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_data <= '0;
            rx_hblank <= 1'b0;
            rx_vblank <= 1'b0;
            rx_valid <= 1'b0;
        end else begin
            rx_hblank <= vid.out_hblank;
            rx_vblank <= vid.out_vblank;
            rx_valid <= vid.out_valid; // [R16]
            if (vid.out_valid) begin // [R16]
                rx_data <= vid.out_data; // [R6]
            end
        end
    end
endmodule

/* File: nr_dev.sv */
// Denoise stream port: line delay, blanking alignment and fixed-strength smoothing
// Contract
// [R1] Source drives input stream on core clock
// [R2] All output stream signals come from core clock
// [R3] Video clock lines of both bundles ignored
// [R4] Input syncs, field flag, chroma-active ignored
// [R5] No sync or field outputs are produced
// [R6] Pixels packed Cb high, Cr middle, Y low
// [R7] Input pixel used only while valid high
// [R8] Frame blanking marks frame end for updates
// [R9] Low clock enable freezes all internal state
// [R10] Low enable holds outputs, samples no inputs
// [R11] Clear works even with enable low
// [R12] Clear zeroes outputs and internal flops
// [R13] Rising edge, enable high, clear high
// [R14] Core clock equals or tracks pixel clock
// [R15] Blanking outputs aligned with output pixels
// [R16] Output valid marks valid output pixels only
// [R17] No processor ports, strength not changeable
// [R18] Latency is one line plus 18 cycles
// [R19] Settings copied at blanking rise if done
// [R20] Strength is a build-time constant
module nr_dev import nr_pkg::*; #(
    parameter int WIDTH = NR_WIDTH,
    parameter int LINE_LEN = NR_LINE_LEN,
    parameter int FIX_DELAY = NR_FIX_DELAY,
    parameter logic [NR_STRENGTH_W-1:0] STRENGTH = NR_STRENGTH
) (
    nr_stream_if.dev vid,
    input wire logic clk,
    input wire logic ce,
    input wire logic sclr,
    output logic [NR_STRENGTH_W-1:0] active_strength
);
    localparam int DW = NR_COMPS * WIDTH;
    localparam int WW = DW + 3;
    localparam int DEPTH = LINE_LEN + FIX_DELAY - NR_PIPE_REGS;
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL_FILL = (AW+1)'(DEPTH);

    // Weighted blend of one component with its left neighbour
    function automatic logic [WIDTH-1:0] blend(
        input logic [WIDTH-1:0] cur,
        input logic [WIDTH-1:0] prev,
        input logic [NR_STRENGTH_W-1:0] s
    );
        logic [WIDTH+2:0] acc;
        logic [2:0] wc;
        acc = '0;
        wc = 3'(NR_WEIGHT_SUM) - {1'b0, s};
        // Widen before multiplying so the product cannot wrap at component width
        acc = (WIDTH+3)'((WIDTH+3)'(cur) * (WIDTH+3)'(wc))
            + (WIDTH+3)'((WIDTH+3)'(prev) * (WIDTH+3)'({1'b0, s}));
        return WIDTH'(acc >> NR_WEIGHT_SHIFT);
    endfunction

    function automatic logic [WIDTH-1:0] comp(input logic [DW-1:0] pix, input int idx);
        return pix[idx*WIDTH +: WIDTH];
    endfunction

    logic [DW-1:0] s0_data;
    logic s0_hblank;
    logic s0_vblank;
    logic s0_valid;
    logic vblank_last;
    logic vblank_rise;
    logic [WW-1:0] line_mem [DEPTH];
    logic [AW-1:0] line_ptr;
    logic [AW:0] fill;
    logic [WW-1:0] rd_word;
    logic rd_ok;
    logic [DW-1:0] rd_pix;
    logic rd_hblank;
    logic rd_vblank;
    logic rd_valid;
    logic [DW-1:0] prev_pix;
    logic prev_ok;
    logic [DW-1:0] next_pix;

    // Only data, blanking and valid are looked at; the other bundle lines are left unread
    always_ff @(posedge clk) begin // [R3] [R4] [R13]
        if (sclr) begin // [R11] [R12]
            s0_data <= '0;
            s0_hblank <= 1'b0;
            s0_vblank <= 1'b0;
            s0_valid <= 1'b0;
        end else if (ce) begin // [R9] [R10]
            s0_data <= vid.in_valid ? vid.in_data : '0; // [R7]
            s0_hblank <= vid.in_hblank;
            s0_vblank <= vid.in_vblank;
            s0_valid <= vid.in_valid;
        end
    end

    always_ff @(posedge clk) begin
        if (sclr) begin // [R12]
            vblank_last <= 1'b0;
        end else if (ce) begin // [R9]
            vblank_last <= s0_vblank;
        end
    end

    assign vblank_rise = s0_vblank && !vblank_last; // [R8]

    // Double-buffer transfer; the shadow value is fixed at build time
    always_ff @(posedge clk) begin
        if (sclr) begin // [R12]
            active_strength <= NR_STRENGTH_RESET;
        end else if (ce && vblank_rise && NR_WRITE_DONE) begin // [R19] [R8]
            active_strength <= STRENGTH; // [R20] [R17]
        end
    end

    // Line store holds blanking and valid with the pixel so they stay in phase
    always_ff @(posedge clk) begin
        if (ce && !sclr) begin // [R9]
            line_mem[line_ptr] <= {s0_valid, s0_vblank, s0_hblank, s0_data}; // [R15]
        end
    end

    always_ff @(posedge clk) begin
        if (sclr) begin // [R12]
            line_ptr <= '0;
        end else if (ce) begin
            line_ptr <= (line_ptr == LAST_ADDR) ? '0 : AW'(line_ptr + 1'b1); // [R18]
        end
    end

    // RAM contents cannot be cleared, so reads are masked until all LINE_LEN+16 entries are written
    always_ff @(posedge clk) begin
        if (sclr) begin // [R12]
            fill <= '0;
        end else if (ce && fill != FULL_FILL) begin
            fill <= (AW+1)'(fill + 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (sclr) begin // [R12]
            rd_word <= '0;
            rd_ok <= 1'b0;
        end else if (ce) begin // [R10]
            rd_word <= line_mem[line_ptr]; // [R18]
            rd_ok <= (fill == FULL_FILL);
        end
    end

    assign rd_pix = rd_word[DW-1:0];
    assign rd_hblank = rd_ok && rd_word[DW];
    assign rd_vblank = rd_ok && rd_word[DW+1];
    assign rd_valid = rd_ok && rd_word[DW+2];

    // First pixel after a gap has no neighbour and passes unblended
    always_comb begin
        next_pix = '0;
        for (int c = 0; c < NR_COMPS; c++) begin
            next_pix[c*WIDTH +: WIDTH] = prev_ok
                ? blend(comp(rd_pix, c), comp(prev_pix, c), active_strength)
                : comp(rd_pix, c); // [R6]
        end
    end

    always_ff @(posedge clk) begin
        if (sclr) begin // [R12]
            prev_pix <= '0;
            prev_ok <= 1'b0;
        end else if (ce) begin // [R9]
            prev_ok <= rd_valid;
            if (rd_valid) begin
                prev_pix <= rd_pix;
            end
        end
    end

    // Outputs are flops on the core clock and hold while enable is low
    always_ff @(posedge clk) begin // [R2] [R5]
        if (sclr) begin // [R11] [R12]
            vid.out_data <= '0;
            vid.out_hblank <= 1'b0;
            vid.out_vblank <= 1'b0;
            vid.out_valid <= 1'b0;
        end else if (ce) begin // [R10]
            vid.out_data <= rd_valid ? next_pix : '0;
            vid.out_hblank <= rd_hblank; // [R15]
            vid.out_vblank <= rd_vblank; // [R15]
            vid.out_valid <= rd_valid; // [R16]
        end
    end
endmodule

/* File: nr_stream_monitor.sv */
// Checker for the denoise stream port, watching the stream bundle and its controls
module nr_stream_monitor import nr_pkg::*; #(
    parameter int WIDTH = NR_WIDTH,
    parameter int LINE_LEN = NR_LINE_LEN,
    parameter logic [NR_STRENGTH_W-1:0] STRENGTH = NR_STRENGTH
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic sclr,
    input wire logic [3*WIDTH-1:0] in_data,
    input wire logic in_hblank,
    input wire logic in_vblank,
    input wire logic in_valid,
    input wire logic [3*WIDTH-1:0] out_data,
    input wire logic out_hblank,
    input wire logic out_vblank,
    input wire logic out_valid,
    input wire logic [NR_STRENGTH_W-1:0] active_strength
);
    // Output flops update on the LINE_LEN+18th edge after capture, seen one edge later
    localparam int LAT = LINE_LEN + NR_FIX_DELAY + 1;
    int run;
    // Only an unbroken run of enabled edges lets the delay line be compared end to end
    always_ff @(posedge clk) begin
        if (sclr || !ce) begin
            run <= 0;
        end else if (run < LAT) begin
            run <= run + 1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sclr);
    chk_latency_valid: assert property (
        run >= LAT |-> out_valid == $past(in_valid, LAT))
        else $error("output valid not aligned to input after line delay");
    chk_blank_align: assert property (
        run >= LAT |-> out_hblank == $past(in_hblank, LAT)
        && out_vblank == $past(in_vblank, LAT))
        else $error("blanking outputs not aligned with pixels");
    chk_data_path: assert property (
        run >= LAT && $past(in_valid, LAT)
        && active_strength == '0 |-> out_data == $past(in_data, LAT))
        else $error("unsmoothed pixel changed on its way through");
    chk_clear_zero: assert property (
        disable iff (1'b0) sclr |=> out_data == '0
        && !out_valid && !out_hblank && !out_vblank && active_strength == '0)
        else $error("clear left an output set");
    chk_ce_hold: assert property (
        !ce |=> $stable(out_data) && $stable(out_valid)
        && $stable(out_hblank) && $stable(out_vblank) && $stable(active_strength))
        else $error("output moved while enable low");
    chk_strength_load: assert property (
        ce && in_vblank ##1 ce |=> active_strength == STRENGTH)
        else $error("strength not loaded at frame end");
    chk_strength_fixed: assert property (
        active_strength != '0 |=> active_strength == STRENGTH)
        else $error("strength left its built value");
    chk_invalid_zero: assert property (!out_valid |-> out_data == '0)
        else $error("invalid output carries data");
    cover property (ce && in_vblank ##1 ce);
    cover property (!ce ##1 !ce);
    cover property (out_valid && run >= LAT);
endmodule

/* File: tb_top.sv */
// Self-checking bench: partner end feeds the denoise port, scoreboard on the receive side
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    $display("[FAIL] %s exp %h got %h", n, e, g); miscompares++; end end
module tb_top import nr_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = NR_WIDTH;
    localparam int LL = 16;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [3*W-1:0] tx_data = '0;
    logic tx_hblank = 1'b0;
    logic tx_vblank = 1'b0;
    logic tx_active = 1'b0;
    logic tx_valid = 1'b0;
    logic drain_en = 1'b0;
    logic hold = 1'b1;
    logic [1:0] ce_d = 2'h0;
    logic tx_ready, rx_hblank, rx_vblank, rx_valid;
    logic [3*W-1:0] rx_data;
    logic [3*W+1:0] exp_w;
    logic [NR_STRENGTH_W-1:0] strength;
    logic [3*W+1:0] expq[$];
    int miscompares = 0;
    int samples_checked = 0;

    nr_stream_if #(.WIDTH(W)) vif ();
    nr_dev #(.LINE_LEN(LL)) i_nr_dev (.vid(vif.dev), .clk(clk), .ce(ce), .sclr(rst),
        .active_strength(strength));
    nr_peer i_nr_peer (.vid(vif.peer), .clk(clk), .rst(rst), .tx_data(tx_data),
        .tx_hblank(tx_hblank), .tx_vblank(tx_vblank), .tx_active(tx_active),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .drain_en(drain_en), .rx_data(rx_data),
        .rx_hblank(rx_hblank), .rx_vblank(rx_vblank), .rx_valid(rx_valid));
    nr_stream_monitor #(.LINE_LEN(LL)) i_nr_stream_monitor (.clk(clk), .ce(ce), .sclr(rst),
        .in_data(vif.in_data), .in_hblank(vif.in_hblank), .in_vblank(vif.in_vblank),
        .in_valid(vif.in_valid), .out_data(vif.out_data), .out_hblank(vif.out_hblank),
        .out_vblank(vif.out_vblank), .out_valid(vif.out_valid), .active_strength(strength));

    initial forever #(NR_CLK_PERIOD_NS / 2) clk = ~clk;

    always @(posedge clk) drain_en <= !hold && ($urandom_range(3) != 0);

    // A frozen output is copied again each cycle, so only words launched by an enabled edge count
    always @(posedge clk) begin
        ce_d <= {ce_d[0], ce};
        if (rx_valid && ce_d[1]) begin
            exp_w = (expq.size() != 0) ? expq.pop_front() : 'X;
            `CHK("rx_data", exp_w[3*W-1:0], rx_data)
            `CHK("rx_hblank", exp_w[3*W], rx_hblank)
            `CHK("rx_vblank", exp_w[3*W+1], rx_vblank)
        end
    end

    task automatic push(input logic [3*W-1:0] d, input logic hb, input logic vb, input logic act);
        logic ok;
        tx_data <= d;
        tx_hblank <= hb;
        tx_vblank <= vb;
        tx_active <= act;
        tx_valid <= 1'b1;
        do begin
            @(negedge clk);
            ok = tx_ready;
            @(posedge clk);
        end while (ok !== 1'b1);
        if (act) expq.push_back({vb, hb, d});
    endtask

    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_sim();
    end

    initial begin
        void'($urandom(41039));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (NR_FIFO_DEPTH) push((3*W)'($urandom), 1'b0, 1'b0, 1'b1);
        @(negedge clk);
        `CHK("tx_ready", 1'b0, tx_ready)
        @(posedge clk);
        hold <= 1'b0;
        for (int i = 0; i < 60; i++) begin
            push((3*W)'($urandom), 1'($urandom), 1'b0, 1'($urandom_range(4) != 0));
            if (i == 30) begin
                tx_valid <= 1'b0;
                hold <= 1'b1;
                repeat (3) @(posedge clk);
                ce <= 1'b0;
                repeat (6) @(posedge clk);
                ce <= 1'b1;
                hold <= 1'b0;
            end
        end
        tx_valid <= 1'b0;
        for (int n = 0; n < 400 && expq.size() != 0; n++) @(posedge clk);
        `CHK("queue", 0, expq.size())
        push('0, 1'b0, 1'b1, 1'b0);
        tx_valid <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK("strength", NR_STRENGTH, strength)
        ce <= 1'b0;
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        ce <= 1'b1;
        @(negedge clk);
        `CHK("cleared strength", 2'h0, strength)
        `CHK("cleared vblank", 1'b0, vif.out_vblank)
        end_sim();
    end
endmodule
